/* File: logic/pmi_pkg.sv */
// Constants and carrier types for the management interrupt block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package pmi_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_ENABLE = 8'h12;
  localparam logic [7:0] IDX_STATUS = 8'h13;
  localparam int ADDR_SCALE = 4;
  // Width of the two registers
  localparam int REG_W = 16;
  // Field positions in the enable register
  localparam int EN_FORCE_BIT = 0;
  localparam int EN_GLOBAL_BIT = 1;
  // Field position of the pending bit in the status register
  localparam int ST_PEND_BIT = 2;
  // Lowest bit of the four event fields in both registers
  localparam int EVT_LSB = 4;
  localparam int EVT_W = 4;
  // Reset values
  localparam logic [3:0] EVT_RESET = 4'h0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // Four events, same layout as bits 7..4 of both registers
  typedef struct packed {
    logic an;
    logic speed;
    logic duplex;
    logic link;
  } pmi_evt_t;

  // Line state sampled from the physical layer
  typedef struct packed {
    logic an_done;
    logic speed_100;
    logic full_duplex;
    logic link_up;
  } pmi_line_t;
endpackage

/* File: logic/pmi_irq.sv */
// Management interrupt logic: event flags, gates and interrupt pins.
// Assumes an APB master on pclk and line state synchronous to pclk.
//
// Operation
// - Negotiation-done event needs its gate bit
// - Speed event needs its gate bit
// - Duplex event needs its gate bit
// - Link event needs its gate bit
// - Global gate off disables all event interrupts; test force still drives the pin
// - Test force drives interrupt pin low
// - Flag set when negotiation completes
// - Flag set when speed changes
// - Flag set when duplex mode changes
// - Flag set when link state changes
// - Reading status register clears event flags
// - Read-only pending bit shows interrupt pending
`timescale 1ns/10ps
module pmi_irq #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pmi_pkg::pmi_line_t line_state,
  output logic mgmt_irq_n,
  output logic irq
);

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_ENABLE =
    ADDR_W'(pmi_pkg::IDX_ENABLE * pmi_pkg::ADDR_SCALE);
  localparam logic [ADDR_W-1:0] ADDR_STATUS =
    ADDR_W'(pmi_pkg::IDX_STATUS * pmi_pkg::ADDR_SCALE);

  // Software state
  pmi_pkg::pmi_evt_t event_gate; // Per-event gate bits
  logic irq_global_gate; // Global enable
  logic irq_test_force; // Force interrupt pin
  // Hardware state
  pmi_pkg::pmi_evt_t flags; // Sticky event flags
  pmi_pkg::pmi_evt_t captured; // Flags handed out by a status read
  pmi_pkg::pmi_line_t line_prev; // Line state one cycle ago
  logic primed; // Line history valid

  // Bus phase decode
  wire setup_phase = psel && !penable;
  wire access_phase = psel && penable;
  wire hit_enable = (paddr == ADDR_ENABLE);
  wire hit_status = (paddr == ADDR_STATUS);
  wire hit_any = hit_enable || hit_status;
  wire wr_enable = access_phase && pwrite && hit_enable && pstrb[0];
  wire rd_status = access_phase && !pwrite && hit_status;

  // Zero-wait slave, error on unmapped address
  assign pready = 1'b1;
  assign pslverr = access_phase && !hit_any;

  // Edge detection on the line state
  wire an_rise = primed && line_state.an_done && !line_prev.an_done;
  wire speed_chg = primed && (line_state.speed_100 != line_prev.speed_100);
  wire duplex_chg = primed && (line_state.full_duplex != line_prev.full_duplex);
  wire link_chg = primed && (line_state.link_up != line_prev.link_up);
  wire pmi_pkg::pmi_evt_t set_evt = '{an: an_rise, speed: speed_chg,
    duplex: duplex_chg, link: link_chg};

  // Flags handed out are dropped at the read; new sets win
  wire pmi_pkg::pmi_evt_t clr_evt = rd_status ? captured : pmi_pkg::EVT_RESET;
  wire pmi_pkg::pmi_evt_t next_flags = (flags & ~clr_evt) | set_evt;

  // Gated events and interrupt condition
  wire pmi_pkg::pmi_evt_t gated = flags & event_gate;
  wire pending = (irq_global_gate && |gated) || irq_test_force;
  assign irq = !mgmt_irq_n;

  // Read images; reserved bits read as zero
  wire [pmi_pkg::REG_W-1:0] enable_img = pmi_pkg::REG_W'({event_gate, 2'b00,
    irq_global_gate, irq_test_force});
  wire [pmi_pkg::REG_W-1:0] status_img = pmi_pkg::REG_W'({flags, 1'b0,
    pending, 2'b00});
  wire [pmi_pkg::REG_W-1:0] read_img = hit_enable ? enable_img :
    (hit_status ? status_img : '0);

  // Line history, first cycle after reset only primes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_prev <= pmi_pkg::EVT_RESET;
      primed <= 1'b0;
    end else begin
      line_prev <= line_state;
      primed <= 1'b1;
    end
  end

  // Sticky event flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= pmi_pkg::EVT_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // Control register; reserved bits are not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_gate <= pmi_pkg::EVT_RESET;
      irq_global_gate <= 1'b0;
      irq_test_force <= 1'b0;
    end else if (wr_enable) begin
      event_gate <= pwdata[pmi_pkg::EVT_LSB +: pmi_pkg::EVT_W];
      irq_global_gate <= pwdata[pmi_pkg::EN_GLOBAL_BIT];
      irq_test_force <= pwdata[pmi_pkg::EN_FORCE_BIT];
    end
  end

  // Read data taken in setup, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= pmi_pkg::RDATA_RESET;
      captured <= pmi_pkg::EVT_RESET;
    end else if (setup_phase) begin
      prdata <= {16'h0000, read_img};
      captured <= (hit_status && !pwrite) ? flags : pmi_pkg::EVT_RESET;
    end
  end

  // Interrupt pin, active low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mgmt_irq_n <= 1'b1;
    end else begin
      mgmt_irq_n <= !pending;
    end
  end

  // Checks
  // Lone negotiation flag reaches the pin only through its gate
  property p_an_gate;
    @(posedge pclk) disable iff (!presetn)
    (flags == 4'h8 && !irq_test_force && irq_global_gate)
      |=> (mgmt_irq_n == !$past(event_gate.an));
  endproperty
  a_an_gate: assert property (p_an_gate) else $error("an gate wrong");

  // Lone speed flag reaches the pin only through its gate
  property p_speed_gate;
    @(posedge pclk) disable iff (!presetn)
    (flags == 4'h4 && !irq_test_force && irq_global_gate)
      |=> (mgmt_irq_n == !$past(event_gate.speed));
  endproperty
  a_speed_gate: assert property (p_speed_gate) else $error("speed gate wrong");

  // Lone duplex flag reaches the pin only through its gate
  property p_duplex_gate;
    @(posedge pclk) disable iff (!presetn)
    (flags == 4'h2 && !irq_test_force && irq_global_gate)
      |=> (mgmt_irq_n == !$past(event_gate.duplex));
  endproperty
  a_duplex_gate: assert property (p_duplex_gate) else $error("duplex gate wrong");

  // Lone link flag reaches the pin only through its gate
  property p_link_gate;
    @(posedge pclk) disable iff (!presetn)
    (flags == 4'h1 && !irq_test_force && irq_global_gate)
      |=> (mgmt_irq_n == !$past(event_gate.link));
  endproperty
  a_link_gate: assert property (p_link_gate) else $error("link gate wrong");

  // Global gate off and no force keep the pin high
  property p_global_off;
    @(posedge pclk) disable iff (!presetn)
    (!irq_global_gate && !irq_test_force) |=> mgmt_irq_n;
  endproperty
  a_global_off: assert property (p_global_off) else $error("irq while disabled");

  // Force pulls the pin low one cycle later
  property p_force;
    @(posedge pclk) disable iff (!presetn)
    irq_test_force |=> !mgmt_irq_n && irq;
  endproperty
  a_force: assert property (p_force) else $error("force ignored");

  // Rising negotiation-done sets its flag
  property p_an_set;
    @(posedge pclk) disable iff (!presetn)
    (primed && line_state.an_done && !line_prev.an_done) |=> flags.an;
  endproperty
  a_an_set: assert property (p_an_set) else $error("an flag not set");

  // Speed change sets its flag
  property p_speed_set;
    @(posedge pclk) disable iff (!presetn)
    (primed && $changed(line_state.speed_100)) |=> flags.speed;
  endproperty
  a_speed_set: assert property (p_speed_set) else $error("speed flag not set");

  // Duplex change sets its flag
  property p_duplex_set;
    @(posedge pclk) disable iff (!presetn)
    (primed && $changed(line_state.full_duplex)) |=> flags.duplex;
  endproperty
  a_duplex_set: assert property (p_duplex_set) else $error("duplex flag not set");

  // Link change sets its flag
  property p_link_set;
    @(posedge pclk) disable iff (!presetn)
    (primed && $changed(line_state.link_up)) |=> flags.link;
  endproperty
  a_link_set: assert property (p_link_set) else $error("link flag not set");

  // Flags returned by a status read are cleared
  property p_read_clear;
    @(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && hit_status) ##1 (access_phase && set_evt == 4'h0)
      |=> ((flags & $past(captured)) == 4'h0);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flags not cleared");

  // Pending bit in the read image follows the interrupt condition
  property p_pend_bit;
    @(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && hit_status)
      |=> (prdata[pmi_pkg::ST_PEND_BIT] == $past(pending)) && (prdata[31:8] == 24'h0);
  endproperty
  a_pend_bit: assert property (p_pend_bit) else $error("pending bit wrong");

  // Condition held two cycles shows on the pin
  property p_pin;
    @(posedge pclk) disable iff (!presetn)
    pending [*2] |-> !mgmt_irq_n;
  endproperty
  a_pin: assert property (p_pin) else $error("pin not low");

  // Any change seen while a read clears the flags survives it
  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
    (rd_status && |set_evt) |=> ((flags & $past(set_evt)) == $past(set_evt));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("change lost to clear");

  // Without a change or a status read the flags keep their value
  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    (!rd_status && set_evt == 4'h0) |=> (flags == $past(flags));
  endproperty
  a_hold: assert property (p_hold) else $error("flag moved");

  // Flagged events with all their gates shut leave the pin high
  property p_shut;
    @(posedge pclk) disable iff (!presetn)
    (!irq_test_force && ((flags & event_gate) == 4'h0)) |=> mgmt_irq_n;
  endproperty
  a_shut: assert property (p_shut) else $error("leak");

  // Status image carries the flags and reads zero in reserved bits 3 and 1..0
  property p_status_img;
    @(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && hit_status)
      |=> (prdata[pmi_pkg::EVT_LSB +: pmi_pkg::EVT_W] == $past(flags))
        && (prdata[3] == 1'b0) && (prdata[1:0] == 2'b00);
  endproperty
  a_status_img: assert property (p_status_img) else $error("status image wrong");

  // A full enable write lands in the gate bits at once
  property p_enable_wr;
    @(posedge pclk) disable iff (!presetn)
    wr_enable |=> (event_gate == $past(pwdata[pmi_pkg::EVT_LSB +: pmi_pkg::EVT_W]))
      && (irq_global_gate == $past(pwdata[pmi_pkg::EN_GLOBAL_BIT]))
      && (irq_test_force == $past(pwdata[pmi_pkg::EN_FORCE_BIT]));
  endproperty
  a_enable_wr: assert property (p_enable_wr) else $error("write lost");

  // A write without the low byte strobe changes nothing
  property p_strobe_off;
    @(posedge pclk) disable iff (!presetn)
    (access_phase && pwrite && hit_enable && !pstrb[0])
      |=> $stable(event_gate) && $stable(irq_global_gate) && $stable(irq_test_force);
  endproperty
  a_strobe_off: assert property (p_strobe_off) else $error("write without strobe");

  // Main scenarios
  // Gated event pulls the pin
  c_gated_irq: cover property (@(posedge pclk) disable iff (!presetn)
    (|gated && irq_global_gate) ##1 !mgmt_irq_n);
  // Read empties the flags
  c_read_clear: cover property (@(posedge pclk) disable iff (!presetn)
    (rd_status && |captured) ##1 (flags == 4'h0));
  // Change meets a clearing read
  c_set_on_clear: cover property (@(posedge pclk) disable iff (!presetn)
    rd_status && |(captured & set_evt));
  // Unmapped address answered with an error
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
  // Test force pulls the pin
  c_forced: cover property (@(posedge pclk) disable iff (!presetn)
    irq_test_force ##1 !mgmt_irq_n);

endmodule

/* File: sim/pmi_host_model.sv */
// Host model: an APB master that stands in for the station management controller.
// Assumes the bench pulses go for one cycle, then waits for done.
`timescale 1ns/10ps
module pmi_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] strb,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic done,
  output logic [31:0] rdata,
  output logic err
);
  // Setup, then access until pready, then release with scrambled lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 8'h00;
      pwdata <= 32'h0000_0000;
      pstrb <= 4'h0;
      done <= 1'b0;
      rdata <= 32'h0000_0000;
      err <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!psel && go) begin
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata & 32'h0000_00F3;
        pstrb <= strb;
      end else if (psel && !penable) begin
        penable <= 1'b1;
      end else if (penable && pready) begin
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
        rdata <= prdata;
        err <= pslverr;
        done <= 1'b1;
      end
    end
  end
endmodule

/* File: sim/test_pmi_irq.sv */
// Testbench for the management interrupt block, driven through the host model.
// Assumes pclk at 50 MHz and line state synchronous to pclk.
`timescale 1ns/10ps
module test_pmi_irq;
  localparam logic [7:0] A_EN = 8'(pmi_pkg::IDX_ENABLE * pmi_pkg::ADDR_SCALE);
  localparam logic [7:0] A_ST = 8'(pmi_pkg::IDX_STATUS * pmi_pkg::ADDR_SCALE);
  logic pclk = 1'b0, presetn = 1'b0, go = 1'b0, wr = 1'b0;
  logic [7:0] addr = 8'h00, paddr;
  logic [31:0] wdata = 32'h0000_0000, pwdata, prdata, rdata;
  logic psel, penable, pwrite, pready, pslverr, done, err, mgmt_irq_n, irq;
  logic [3:0] pstrb, strb = 4'hF;
  pmi_pkg::pmi_line_t line_state = '0;
  int failures = 0, n_tests = 0;
  // Clock, 20 ns period
  always #10 pclk = ~pclk;
  pmi_irq #(.ADDR_W(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_state(line_state), .mgmt_irq_n(mgmt_irq_n),
    .irq(irq));
  pmi_host_model host (.pclk(pclk), .presetn(presetn), .go(go), .wr(wr), .addr(addr),
    .wdata(wdata), .strb(strb), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .done(done), .rdata(rdata), .err(err));
  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Compare seen against expected
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer through the host model, bounded wait for done
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    go <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge pclk);
    go <= 1'b0;
    for (i = 0; i < 20; i++) begin
      #1;
      if (done === 1'b1) break;
      @(posedge pclk);
    end
    if (done !== 1'b1) begin
      failures++;
      $display("[FAIL] transfer expected done seen none");
      wrap_up();
    end
  endtask
  // Expected pending level
  function automatic logic exp_pend(logic [3:0] g, logic gl, logic f, logic [3:0] fl);
    return (gl & |(g & fl)) | f;
  endfunction
  // Main sequence
  initial begin
    logic [3:0] g, nl, ev, cur;
    logic gl, p;
    int k;
    void'($urandom(21));
    cur = 4'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, A_EN, 32'h0);
    check("enable reset", rdata, 32'h0000_0000);
    xfer(1'b0, A_ST, 32'h0);
    check("status reset", rdata, 32'h0000_0000);
    check("irq reset", {mgmt_irq_n, irq}, 32'h0000_0002);
    xfer(1'b0, 8'h40, 32'h0);
    check("unmapped", {err, rdata[30:0]}, 32'h8000_0000);
    $display("test reset and unmapped done");
    xfer(1'b1, A_EN, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    #1;
    check("forced irq", {mgmt_irq_n, irq}, 32'h0000_0001);
    xfer(1'b0, A_ST, 32'h0);
    check("forced pending", rdata, 32'h0000_0004);
    $display("test force done");
    for (k = 0; k < 24; k++) begin
      g = 4'($urandom);
      gl = 1'($urandom);
      xfer(1'b1, A_EN, {16'($urandom), 8'h00, g, 2'b11, gl, 1'b0});
      xfer(1'b0, A_EN, 32'h0);
      check("enable readback", rdata, {24'h0, g, 2'b00, gl, 1'b0});
      nl = 4'($urandom);
      ev = ((nl ^ cur) & 4'h7) | {nl[3] & ~cur[3], 3'b000};
      cur = nl;
      p = exp_pend(g, gl, 1'b0, ev);
      @(posedge pclk);
      line_state <= pmi_pkg::pmi_line_t'(nl);
      repeat (4) @(posedge pclk);
      #1;
      check("irq", {mgmt_irq_n, irq}, {30'h0, ~p, p});
      xfer(1'b0, A_ST, 32'h0);
      check("status", rdata, {24'h0, ev, 1'b0, p, 2'b00});
      xfer(1'b0, A_ST, 32'h0);
      check("status cleared", rdata, 32'h0000_0000);
    end
    $display("test random events done");
    // Strobe-less and status writes leave the registers alone
    xfer(1'b1, A_EN, 32'h0000_0012);
    strb <= 4'hE;
    xfer(1'b1, A_EN, 32'h0000_00F1);
    strb <= 4'hF;
    xfer(1'b1, A_ST, 32'h0000_00F0);
    xfer(1'b0, A_EN, 32'h0);
    check("strobe off", rdata, 32'h0000_0012);
    $display("test write guards done");
    // Link change lands in the clearing cycle of a status read
    @(posedge pclk);
    line_state <= pmi_pkg::pmi_line_t'(cur ^ 4'h1);
    repeat (3) @(posedge pclk);
    fork
      xfer(1'b0, A_ST, 32'h0);
      begin
        repeat (3) @(posedge pclk);
        line_state <= pmi_pkg::pmi_line_t'(cur);
      end
    join
    check("status before race", rdata, 32'h0000_0014);
    check("irq on link", {mgmt_irq_n, irq}, 32'h0000_0001);
    xfer(1'b0, A_ST, 32'h0);
    check("set beats clear", rdata, 32'h0000_0014);
    xfer(1'b0, A_ST, 32'h0);
    check("race cleared", rdata, 32'h0000_0000);
    $display("test set against clear done");
    // Reset in mid-run drops gates and force; the flags are already clear before it
    xfer(1'b1, A_EN, 32'h0000_00F3);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check("irq after reset", {mgmt_irq_n, irq}, 32'h0000_0002);
    xfer(1'b0, A_EN, 32'h0);
    check("enable after reset", rdata, 32'h0000_0000);
    xfer(1'b0, A_ST, 32'h0);
    check("status after reset", rdata, 32'h0000_0000);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule
